/* File: logic/arcr_pkg.sv */
// constants and register map of the converter result/channel/config register set
// Function
// [RQ1] 16-bit read-only latest straight-binary result
// [RQ2] bits 15:13 carry converted input number
// [RQ3] bit 12 alert flag, bits 11:0 sample
// [RQ4] unused tag bits read zero on smaller variants
// [RQ5] channel register holds eight input enable bits
// [RQ6] new selection applies after one more conversion
// [RQ7] new selection restarts at lowest enabled input
// [RQ8] channel bits 15:8 read zero, reset zero
// [RQ9] config 16 bits, bits 15:10, 8 read zero
// [RQ10] soft reset clears control, result, alert only
// [RQ11] soft reset bit clears itself next cycle
// [RQ12] soft reset also requests trim reload
// [RQ13] bit 7 latches alert, resets to one
// [RQ14] latched alert clears only on read or reset
// [RQ15] 16-clock frame: 5-bit address then rw bit
// [RQ16] write at select rise; read next frame
// [RQ17] bad-address writes ignored, reads return zero
// [RQ18] addresses 0x00, 0x01, 0x02; setup resets 0x00C0
// [RQ19] result holds until next conversion or soft reset
// [RQ20] reserved bit writes ignored, read zero
`default_nettype none
package arcr_pkg;
  // register addresses
  localparam logic [4:0]  ADDR_RESULT      = 5'h00;
  localparam logic [4:0]  ADDR_CHANNEL     = 5'h01;
  localparam logic [4:0]  ADDR_CONFIG      = 5'h02;
  // serial frame layout
  localparam int          FRAME_BITS       = 16;
  localparam int          FRAME_ADDR_MSB   = 15;
  localparam int          FRAME_ADDR_LSB   = 11;
  localparam int          FRAME_RW_BIT     = 10;
  // result word fields
  localparam int          RES_TAG_MSB      = 15;
  localparam int          RES_TAG_LSB      = 13;
  localparam int          RES_ALERT_BIT    = 12;
  localparam int          RES_SAMPLE_MSB   = 11;
  // configuration fields
  localparam int          CFG_TRIGGER_BIT  = 9;
  localparam int          CFG_STICKY_BIT   = 7;
  localparam int          CFG_LOW_MSB      = 6;
  // reset values
  localparam logic [15:0] CONFIG_RESET     = 16'h00C0;
  localparam logic [7:0]  CHANNEL_RESET    = 8'h00;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam logic [15:0] READ_ZERO        = 16'h0000;
  // pin synchroniser depth
  localparam int          SYNC_STAGES      = 3;
endpackage : arcr_pkg
`default_nettype wire

/* File: logic/arcr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`default_nettype none
`timescale 1ns/1ps
module arcr_pin_sync #(
  parameter int         WIDTH    = 1,
  parameter logic [0:0] INIT_VAL = 1'h0
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // refuse an empty synchroniser at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("arcr_pin_sync: WIDTH must be at least 1");
  end

  // metastability chain; stage one feeds stage two only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_q <= {WIDTH{INIT_VAL}};
      s2_q <= {WIDTH{INIT_VAL}};
      s3_q <= {WIDTH{INIT_VAL}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a bit once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pin_q[g] <= INIT_VAL[0];
        end else if (s2_q[g] == s3_q[g]) begin
          pin_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate
endmodule : arcr_pin_sync
`default_nettype wire

/* File: logic/arcr_regs.sv */
// serial register bank: result word, input enables, operating setup, sequencer
`default_nettype none
`timescale 1ns/1ps
module arcr_regs #(
  parameter int NUM_INPUTS = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  input  wire logic        conv_done,
  input  wire logic [2:0]  conv_input_tag,
  input  wire logic [11:0] conv_sample,
  input  wire logic        alert_raise,
  input  wire logic        alert_hyst_clear,
  output logic [2:0]       next_input,
  output logic [7:0]       active_enables,
  output logic             trim_reload,
  output logic             alert_flag,
  output logic [6:0]       setup_low_bits
);

  // refuse unsupported variants at elaboration
  if (NUM_INPUTS != 2 && NUM_INPUTS != 4 && NUM_INPUTS != 8) begin : g_bad_inputs
    $error("arcr_regs: NUM_INPUTS must be 2, 4 or 8");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;

  arcr_pin_sync #(
    .WIDTH    (1),
    .INIT_VAL (1'h0)
  ) u_sync_sclk (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_in  (spi_sclk),
    .pin_q   (sclk_s)
  );

  arcr_pin_sync #(
    .WIDTH    (1),
    .INIT_VAL (1'h1)
  ) u_sync_cs (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_in  (spi_cs_n),
    .pin_q   (cs_n_s)
  );

  arcr_pin_sync #(
    .WIDTH    (1),
    .INIT_VAL (1'h0)
  ) u_sync_sdi (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_in  (spi_sdi),
    .pin_q   (sdi_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic        sclk_prev_q;
  logic        cs_n_prev_q;
  logic [15:0] shin_q;
  logic [15:0] shout_q;
  logic [4:0]  bit_cnt_q;
  logic        rd_pend_q;
  logic [4:0]  rd_addr_q;
  logic [2:0]  res_tag_q;
  logic [11:0] res_sample_q;
  logic        alert_q;
  logic [7:0]  chan_q;
  logic [7:0]  active_q;
  logic        sel_pend_q;
  logic [2:0]  cur_in_q;
  logic        sticky_q;
  logic [6:0]  cfg_low_q;
  logic        soft_reset_trigger_q;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        frame_ok;
  logic        wr_req;
  logic        wr_chan;
  logic        wr_cfg;
  logic [4:0]  frame_addr;
  logic [15:0] result_word;
  logic [15:0] read_word;
  logic [7:0]  in_mask;
  logic        load_result;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // next enabled input at or after start, wrapping; zero when none enabled
  function automatic logic [2:0] next_enabled(input logic [7:0] en, input logic [2:0] start);
    logic [2:0] idx;
    logic       hit;
    next_enabled = 3'h0;
    hit = 1'b0;
    for (int k = 0; k < 8; k++) begin
      idx = 3'(start + 3'(k));
      if (!hit && en[idx]) begin
        next_enabled = idx;
        hit = 1'b1;
      end
    end
  endfunction : next_enabled

  // enables usable by this variant
  assign in_mask = 8'(({8'h00, 8'hFF} >> (8 - NUM_INPUTS)) & 16'h00FF);

  //////////////////////////////////////////////////////////////////////////////
  // frame decode

  // edge detection on filtered pins
  assign sclk_rise  = sclk_s & ~sclk_prev_q;
  assign sclk_fall  = ~sclk_s & sclk_prev_q;
  assign cs_fall    = ~cs_n_s & cs_n_prev_q;
  assign cs_rise    = cs_n_s & ~cs_n_prev_q;
  assign frame_ok   = cs_rise && (bit_cnt_q == 5'(arcr_pkg::FRAME_BITS));  // [RQ15]
  assign frame_addr = shin_q[arcr_pkg::FRAME_ADDR_MSB:arcr_pkg::FRAME_ADDR_LSB]; // [RQ15]
  assign wr_req     = frame_ok && shin_q[arcr_pkg::FRAME_RW_BIT];  // [RQ16]
  // writes elsewhere fall through as no-ops
  assign wr_chan    = wr_req && (frame_addr == arcr_pkg::ADDR_CHANNEL);  // [RQ17] [RQ18]
  assign wr_cfg     = wr_req && (frame_addr == arcr_pkg::ADDR_CONFIG);   // [RQ17] [RQ18]

  // result word with tag bits above the variant forced low
  always_comb begin
    result_word = {res_tag_q, alert_q, res_sample_q};  // [RQ1] [RQ2] [RQ3]
    if (NUM_INPUTS <= 4) result_word[arcr_pkg::RES_TAG_MSB] = 1'b0;      // [RQ4]
    if (NUM_INPUTS <= 2) result_word[arcr_pkg::RES_TAG_MSB - 1] = 1'b0;  // [RQ4]
  end

  // readback mux; reserved bits and unknown addresses read zero
  always_comb begin
    read_word = arcr_pkg::READ_ZERO;  // [RQ17]
    unique case (rd_addr_q)
      arcr_pkg::ADDR_RESULT:  read_word = result_word;
      arcr_pkg::ADDR_CHANNEL: read_word = {8'h00, chan_q};  // [RQ8] [RQ20]
      arcr_pkg::ADDR_CONFIG:  read_word = {6'h00, soft_reset_trigger_q, 1'b0, sticky_q,
                                           cfg_low_q}; // [RQ9]
      default:                read_word = arcr_pkg::READ_ZERO;  // [RQ17]
    endcase
  end

  // the result word goes out unless a read of another address was requested
  assign load_result = cs_fall && (!rd_pend_q || rd_addr_q == arcr_pkg::ADDR_RESULT);

  //////////////////////////////////////////////////////////////////////////////
  // serial engine

  // previous pin levels
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_n_prev_q <= cs_n_s;
    end
  end

  // input shifter and bit count, sampled on rising clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shin_q    <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h00;
    end else if (!cs_n_s && sclk_rise) begin
      shin_q <= {shin_q[14:0], sdi_s};
      if (bit_cnt_q != 5'(arcr_pkg::FRAME_BITS)) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;  // [RQ15]
      end
    end
  end

  // output shifter: msb at select fall, next bit on each falling clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shout_q <= 16'h0000;
      spi_sdo <= 1'b0;
    end else if (cs_fall) begin
      shout_q <= rd_pend_q ? read_word : result_word;  // [RQ16]
      spi_sdo <= rd_pend_q ? read_word[15] : result_word[15];
    end else if (!cs_n_s && sclk_fall) begin
      shout_q <= {shout_q[14:0], 1'b0};
      spi_sdo <= shout_q[14];
    end
  end

  // read request captured at select rise, served in the next frame
  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_reset_trigger_q) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= arcr_pkg::ADDR_RESULT;
    end else if (cs_rise) begin
      rd_pend_q <= frame_ok && !shin_q[arcr_pkg::FRAME_RW_BIT];  // [RQ16]
      rd_addr_q <= frame_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // input enables; only the low eight bits exist
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chan_q <= arcr_pkg::CHANNEL_RESET;  // [RQ8]
    end else if (wr_chan) begin
      chan_q <= shin_q[7:0];  // [RQ5] [RQ20]
    end
  end

  // operating setup; soft reset leaves it alone
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sticky_q  <= arcr_pkg::CONFIG_RESET[arcr_pkg::CFG_STICKY_BIT];  // [RQ13] [RQ18]
      cfg_low_q <= arcr_pkg::CONFIG_RESET[arcr_pkg::CFG_LOW_MSB:0];
    end else if (wr_cfg) begin
      sticky_q  <= shin_q[arcr_pkg::CFG_STICKY_BIT];  // [RQ9] [RQ20]
      cfg_low_q <= shin_q[arcr_pkg::CFG_LOW_MSB:0];
    end
  end

  // soft reset bit, high for exactly one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      soft_reset_trigger_q <= 1'b0;
    end else begin
      soft_reset_trigger_q <= wr_cfg && shin_q[arcr_pkg::CFG_TRIGGER_BIT];  // [RQ10] [RQ11]
    end
  end

  // trim reload request pulses in the same cycle as soft reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      trim_reload <= 1'b0;
    end else begin
      trim_reload <= wr_cfg && shin_q[arcr_pkg::CFG_TRIGGER_BIT];  // [RQ12]
    end
  end

  // result holds until the next conversion or soft reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_reset_trigger_q) begin
      res_tag_q    <= arcr_pkg::RESULT_RESET[arcr_pkg::RES_TAG_MSB:arcr_pkg::RES_TAG_LSB];
      res_sample_q <= arcr_pkg::RESULT_RESET[arcr_pkg::RES_SAMPLE_MSB:0];  // [RQ10]
    end else if (conv_done) begin
      res_tag_q    <= conv_input_tag;  // [RQ2] [RQ19]
      res_sample_q <= conv_sample;     // [RQ1] [RQ19]
    end
  end

  // alert flag; a raise wins over a hysteresis or read clear in the same cycle, but soft reset wins over a raise
  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_reset_trigger_q) begin
      alert_q <= 1'b0;  // [RQ10] [RQ14]
    end else if (conv_done && alert_raise) begin
      alert_q <= 1'b1;  // [RQ3]
    end else if (!sticky_q && alert_hyst_clear) begin
      alert_q <= 1'b0;  // [RQ13]
    end else if (load_result) begin
      alert_q <= 1'b0;  // [RQ14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  // pending selection marker; a write landing with a conversion stays pending
  always_ff @(posedge ref_clk) begin
    if (sys_rst || soft_reset_trigger_q) begin
      sel_pend_q <= 1'b0;
    end else if (wr_chan) begin
      sel_pend_q <= 1'b1;  // [RQ6]
    end else if (conv_done) begin
      sel_pend_q <= 1'b0;
    end
  end

  // selection in use and next input to convert
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_q <= arcr_pkg::CHANNEL_RESET;
      cur_in_q <= 3'h0;
    end else if (soft_reset_trigger_q) begin
      active_q <= chan_q & in_mask;
      cur_in_q <= next_enabled(chan_q & in_mask, 3'h0);  // [RQ10]
    end else if (conv_done && sel_pend_q && !wr_chan) begin
      active_q <= chan_q & in_mask;  // [RQ6]
      cur_in_q <= next_enabled(chan_q & in_mask, 3'h0);  // [RQ7]
    end else if (conv_done) begin
      cur_in_q <= next_enabled(active_q, 3'(cur_in_q + 3'h1));  // [RQ5]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign next_input     = cur_in_q;
  assign active_enables = active_q;
  assign alert_flag     = alert_q;
  assign setup_low_bits = cfg_low_q;

endmodule : arcr_regs
`default_nettype wire

/* File: dv/arcr_regs_monitor.sv */
// port checker for the serial register bank
`timescale 1ns/1ps
`default_nettype none
module arcr_regs_monitor #(
  parameter int NUM_INPUTS = 8
) (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        spi_sclk,
  input wire logic        spi_cs_n,
  input wire logic        spi_sdi,
  input wire logic        spi_sdo,
  input wire logic        conv_done,
  input wire logic [2:0]  conv_input_tag,
  input wire logic [11:0] conv_sample,
  input wire logic        alert_raise,
  input wire logic        alert_hyst_clear,
  input wire logic [2:0]  next_input,
  input wire logic [7:0]  active_enables,
  input wire logic        trim_reload,
  input wire logic        alert_flag,
  input wire logic [6:0]  setup_low_bits
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [4:0] cs_hi_q;
  ////////////////////////////////////////////////////////////////
  // cycles since frame select went high, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !spi_cs_n) cs_hi_q <= 5'h00;
    else if (cs_hi_q != 5'h1F) cs_hi_q <= cs_hi_q + 5'h01;
  end
  ////////////////////////////////////////////////////////////////
  a_reset_values: assert property ($fell(sys_rst) |-> setup_low_bits == 7'h40 &&
    active_enables == 8'h00 && next_input == 3'h0 && !alert_flag && !trim_reload && !spi_sdo)
    else $error("outputs not at reset values");
  a_trim_single: assert property (trim_reload |=> !trim_reload)
    else $error("trim reload longer than one cycle");
  a_trim_cause: assert property (trim_reload |-> cs_hi_q inside {[2:14]})
    else $error("trim reload without a frame end");
  a_alert_set: assert property (conv_done && alert_raise && !trim_reload |=> alert_flag)
    else $error("alert not raised");
  a_alert_keep: assert property (alert_flag && !conv_done && !alert_hyst_clear &&
    !$past(alert_hyst_clear) && cs_hi_q >= 5'h0E |=> alert_flag)
    else $error("alert dropped without cause");
  a_next_enabled: assert property (conv_done && !trim_reload |=>
    active_enables == 8'h00 || active_enables[next_input])
    else $error("next input not enabled");
  a_enables_masked: assert property ((active_enables >> NUM_INPUTS) == 8'h00)
    else $error("enable beyond input count");
  a_enables_change: assert property (!$stable(active_enables) |->
    $past(conv_done) || trim_reload || $past(trim_reload))
    else $error("enables changed without conversion");
  a_sdo_idle: assert property (cs_hi_q >= 5'h0E |=> $stable(spi_sdo))
    else $error("data out moved outside frame");
  a_setup_change: assert property (!$stable(setup_low_bits) |-> cs_hi_q inside {[2:14]})
    else $error("setup changed outside frame end");
  c_alert: cover property (conv_done && alert_raise);
  c_trim: cover property (trim_reload);
  c_hyst: cover property (alert_flag && alert_hyst_clear);
endmodule : arcr_regs_monitor
`default_nettype wire

/* File: dv/arcr_spi_host.sv */
// serial host model driving 16-clock frames
`timescale 1ns/1ps
`default_nettype none
module arcr_spi_host (
  input  wire logic ref_clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  localparam int HALF = 8; // ref_clk cycles per half clock
  ////////////////////////////////////////////////////////////////
  // idle: clock still low, select high
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // one frame msb first, sample on rise, shift on fall
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = tx[i];
      repeat (HALF) @(negedge ref_clk);
      spi_sclk = 1'b1;
      rx[i] = spi_sdo;
      repeat (HALF) @(negedge ref_clk);
      spi_sclk = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk);
    spi_sdi = ~spi_sdi; // released line loses last bit
    spi_cs_n = 1'b1;
    repeat (2 * HALF) @(negedge ref_clk);
  endtask : frame
endmodule : arcr_spi_host
`default_nettype wire

/* File: dv/adc_result_channel_config_regs_tb_top.sv */
// self-checking bench for the result, channel and setup registers
`timescale 1ns/1ps
`default_nettype none
module adc_result_channel_config_regs_tb_top;
  logic        ref_clk, sys_rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, conv_done;
  logic        alert_raise, alert_hyst_clear, trim_reload, alert_flag;
  logic [2:0]  conv_input_tag, next_input;
  logic [11:0] conv_sample;
  logic [7:0]  active_enables;
  logic [6:0]  setup_low_bits;
  logic [15:0] rx;
  int          failures, comparisons, cycles, trims, trim_m, res_m, chan_m, act_m, next_m;
  int          low_m, stk_m, pend_m, cpend_m, d;
  arcr_regs #(.NUM_INPUTS(4)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .conv_done(conv_done), .conv_input_tag(conv_input_tag), .conv_sample(conv_sample),
    .alert_raise(alert_raise), .alert_hyst_clear(alert_hyst_clear), .next_input(next_input),
    .active_enables(active_enables), .trim_reload(trim_reload), .alert_flag(alert_flag),
    .setup_low_bits(setup_low_bits));
  arcr_spi_host i_host (.ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
  ////////////////////////////////////////////////////////////////
  // clock, cycle limit and trim pulse count
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (trim_reload === 1'b1) trims++;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  function automatic logic [15:0] word(input int a);
    case (a)
      0: return 16'(res_m);
      1: return 16'(chan_m);
      2: return 16'(stk_m * 128 + low_m);
      default: return 16'h0000;
    endcase
  endfunction : word
  // next enabled input above f, wrapping
  function automatic int nxt(input int s, input int f);
    for (int k = 1; k <= 4; k++) if (((s >> ((f + k) % 4)) & 1) == 1) return (f + k) % 4;
    return 0;
  endfunction : nxt
  // one frame; checks the word asked for by the frame before
  task automatic xfer(input int a, input int w, input int v);
    logic [15:0] exp;
    exp = word(pend_m);
    if (pend_m == 0) res_m = res_m & 32'hEFFF;
    i_host.frame(16'((a << 11) | (w << 10) | (v & 32'h3FF)), rx);
    check(rx, exp);
    if (w == 1 && a == 1) begin
      chan_m = v & 32'hFF;
      cpend_m = 1;
    end
    if (w == 1 && a == 2) begin
      low_m = v & 32'h7F;
      stk_m = (v >> 7) & 1;
    end
    if (w == 1 && a == 2 && ((v >> 9) & 1) == 1) begin
      res_m = 0;
      trim_m++;
      cpend_m = 0;
      act_m = chan_m & 32'hF;
      next_m = nxt(act_m, 3);
    end
    pend_m = (w == 1) ? 0 : a;
  endtask : xfer
  // one conversion with random tag and sample
  task automatic conv(input int r);
    @(negedge ref_clk);
    conv_done = 1'b1;
    conv_input_tag = 3'($urandom);
    conv_sample = 12'($urandom);
    alert_raise = r[0];
    @(negedge ref_clk);
    conv_done = 1'b0;
    alert_raise = 1'b0;
    res_m = (int'(conv_input_tag[1:0]) << 13) | (res_m & 32'h1000) | (r << 12);
    res_m = res_m | int'(conv_sample);
    if (cpend_m == 1) begin
      act_m = chan_m & 32'hF;
      next_m = nxt(act_m, 3);
      cpend_m = 0;
    end else next_m = nxt(act_m, next_m);
    @(negedge ref_clk);
    check(16'(active_enables), 16'(act_m));
    check(16'(next_input), 16'(next_m));
    check(16'(alert_flag), 16'((res_m >> 12) & 1));
  endtask : conv
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    conv_done = 1'b0;
    alert_raise = 1'b0;
    alert_hyst_clear = 1'b0;
    conv_input_tag = 3'h0;
    conv_sample = 12'h000;
    // setup model starts at the documented reset value
    low_m = int'(arcr_pkg::CONFIG_RESET[arcr_pkg::CFG_LOW_MSB:0]);
    stk_m = int'(arcr_pkg::CONFIG_RESET[arcr_pkg::CFG_STICKY_BIT]);
    void'($urandom(68032));
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    check(16'({setup_low_bits, active_enables}), 16'h4000);
    xfer(1, 0, 0);
    xfer(2, 0, 0);
    xfer(31, 1, 1023);
    xfer(0, 1, 1023);
    xfer(5, 0, 0);
    xfer(0, 0, 0);
    for (int i = 0; i < 6; i++) begin
      d = 32'h300 | ($urandom & 32'hF);
      xfer(1, 1, d);
      check(16'(active_enables), 16'(act_m));
      conv(0);
      conv(0);
      xfer(1, 0, 0);
      xfer(0, 0, 0);
    end
    for (int s = 0; s < 2; s++) begin
      xfer(2, 1, (s << 7) | ($urandom & 32'h7F));
      check(16'(setup_low_bits), 16'(low_m));
      conv(1);
      alert_hyst_clear = 1'b1;
      @(negedge ref_clk);
      alert_hyst_clear = 1'b0;
      if (stk_m == 0) res_m = res_m & 32'hEFFF;
      repeat (2) @(negedge ref_clk);
      check(16'(alert_flag), 16'((res_m >> 12) & 1));
      xfer(0, 0, 0);
      check(16'(alert_flag), 16'h0000);
    end
    xfer(2, 1, 32'h380 | ($urandom & 32'h7F));
    check(16'(trims), 16'(trim_m));
    check(16'(setup_low_bits), 16'(low_m));
    xfer(1, 0, 0);
    xfer(2, 0, 0);
    xfer(0, 0, 0);
    end_sim();
  end
endmodule : adc_result_channel_config_regs_tb_top
bind arcr_regs arcr_regs_monitor #(.NUM_INPUTS(NUM_INPUTS)) i_mon (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
  .spi_sdo(spi_sdo), .conv_done(conv_done), .conv_input_tag(conv_input_tag),
  .conv_sample(conv_sample), .alert_raise(alert_raise), .alert_hyst_clear(alert_hyst_clear),
  .next_input(next_input), .active_enables(active_enables), .trim_reload(trim_reload),
  .alert_flag(alert_flag), .setup_low_bits(setup_low_bits));
`default_nettype wire
